// >>> rtl/converter_end.sv
`timescale 1ns/1ps
module converter_end
    import adc_link_pkg::*;
#(
    parameter int ACQ_NS = ACQ_NS_LONG
) (
    input wire logic clk_sys,
    input wire logic rst,
    adc_link_if.device link,
    input wire logic conv_done,
    input wire logic [CODE_BITS-1:0] conv_code,
    output logic conv_go,
    output logic hold,
    output logic [CH_BITS-1:0] channel,
    output logic acquiring,
    output logic powered_down,
    output logic twos_format
);
    localparam int ACQ_CYC = cycles_min(ACQ_NS);
    localparam int AQW = $clog2(ACQ_CYC + 1);
    localparam int SY_START = 0;
    localparam int SY_STBY = 1;
    localparam int SY_RFRAME = 2;
    localparam int SY_CWTOG = 3;
    localparam logic [3:0] SYNC_IDLE = 4'h7;

    typedef enum logic [1:0] {
        ST_TRACK = 2'b00,
        ST_CONVERT = 2'b01,
        ST_ACQUIRE = 2'b10
    } conv_state_type;

    function automatic logic [RD_BITS-1:0] encode(
        input logic [CODE_BITS-1:0] code,
        input logic twos
    );
        logic sign;
        sign = ~code[CODE_BITS-1];
        if (twos) begin
            encode = {{(RD_BITS - CODE_BITS + 1){sign}},
                      code[CODE_BITS-2:0]};
        end else begin
            encode = {{(RD_BITS - CODE_BITS){1'b0}}, code};
        end
    endfunction : encode

    // Link domain: write side samples on the falling serial clock edge.
    logic [2:0] wr_count;
    logic [CW_BITS-2:0] wr_shift;
    logic [CW_BITS-1:0] cw_link;
    logic cw_toggle;
    wire wr_last = wr_count == 3'(CW_BITS - 1);
    wire wr_full = wr_count == 3'(CW_BITS);

    // The frame sync itself clears the counter, since the serial clock
    // stops between frames and no edge is left to do it.
    always_ff @(negedge link.link_clk or posedge rst
                or posedge link.write_frame_sync_n) begin
        if (rst || link.write_frame_sync_n) begin
            wr_count <= '0;
            wr_shift <= '0;
        end else if (!wr_full) begin
            wr_shift <= {wr_shift[CW_BITS-3:0], link.data_in};
            wr_count <= wr_count + 3'h1;
        end
    end

    always_ff @(negedge link.link_clk or posedge rst) begin
        if (rst) begin
            cw_link <= CW_RESET;
            cw_toggle <= 1'b0;
        end else if (!link.write_frame_sync_n && wr_last) begin
            cw_link <= {wr_shift, link.data_in};
            cw_toggle <= ~cw_toggle;
        end
    end

    // Link domain: read side advances on the rising serial clock edge.
    logic [4:0] rd_count;
    logic [RD_BITS-1:0] result_word;
    wire [3:0] rd_index = 4'(RD_BITS - 1) - rd_count[3:0];

    always_ff @(posedge link.link_clk or posedge rst
                or posedge link.read_frame_sync_n) begin
        if (rst || link.read_frame_sync_n) begin
            rd_count <= '0;
        end else if (rd_count != 5'(RD_BITS)) begin
            rd_count <= rd_count + 5'h1;
        end
    end

    // The result word is frozen by the system side while a read frame
    // is seen active, so the link side may read it without a crossing.
    assign link.data_out = result_word[rd_index];
    assign link.data_out_oe = !link.read_frame_sync_n;

    // System domain: three-stage synchronisers for pins and the toggle.
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] stable;
    wire [3:0] raw_in = {cw_toggle, link.read_frame_sync_n,
                         link.standby_n, link.conversion_start_n};
    wire [3:0] next_stable = (sync2 & sync3) | (stable & (sync2 ^ sync3));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
            sync3 <= SYNC_IDLE;
            stable <= SYNC_IDLE;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            stable <= next_stable;
        end
    end

    wire start_rise = next_stable[SY_START] & ~stable[SY_START];
    wire frame_active = ~stable[SY_RFRAME];
    wire frame_begin = ~next_stable[SY_RFRAME] & stable[SY_RFRAME];
    wire cw_event = next_stable[SY_CWTOG] ^ stable[SY_CWTOG];

    // The control word is held still by the link side for a whole frame
    // after its toggle moves, so it is safe to copy on the toggle.
    logic [CW_BITS-1:0] ctrl;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl <= CW_RESET;
        end else if (cw_event) begin
            ctrl <= cw_link;
        end
    end

    wire standby_now = ~stable[SY_STBY] | ctrl[CW_PWRDN];
    wire sw_start = cw_event & cw_link[CW_SWCONV];
    wire start_ok = (start_rise | sw_start) & ~standby_now;

    assign powered_down = standby_now;
    assign channel = ctrl[CH_BITS-1:0];
    assign twos_format = ctrl[CW_FORMAT];

    // Conversion sequencing.
    conv_state_type state;
    conv_state_type next_state;
    logic [AQW-1:0] acq_count;
    wire acq_end = acq_count == AQW'(ACQ_CYC - 1);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_TRACK: begin
                if (start_ok) begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (standby_now) begin
                    next_state = ST_TRACK;
                end else if (conv_done) begin
                    next_state = ST_ACQUIRE;
                end
            end
            ST_ACQUIRE: begin
                if (start_ok) begin
                    next_state = ST_CONVERT;
                end else if (acq_end) begin
                    next_state = ST_TRACK;
                end
            end
            default: begin
                next_state = ST_TRACK;
            end
        endcase
    end

    assign hold = state == ST_CONVERT;
    assign acquiring = state == ST_ACQUIRE;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_TRACK;
            conv_go <= 1'b0;
            acq_count <= '0;
        end else begin
            state <= next_state;
            conv_go <= (state != ST_CONVERT) && next_state == ST_CONVERT;
            acq_count <= (state == ST_ACQUIRE && !acq_end)
                ? acq_count + AQW'(1) : '0;
        end
    end

    // Result publishing waits for any read frame to finish.
    logic [CODE_BITS-1:0] raw_code;
    logic raw_new;
    logic eoc_n_reg;
    wire captured = state == ST_CONVERT && conv_done && !standby_now;
    wire publish = raw_new && !frame_active;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            raw_code <= '0;
            raw_new <= 1'b0;
            result_word <= WORD_ZERO;
            eoc_n_reg <= 1'b1;
        end else begin
            if (captured) begin
                raw_code <= conv_code;
            end
            raw_new <= captured | (raw_new & ~publish);
            if (publish) begin
                result_word <= encode(raw_code, ctrl[CW_FORMAT]);
            end
            if (publish) begin
                eoc_n_reg <= 1'b0;
            end else if (conv_go || frame_begin) begin
                eoc_n_reg <= 1'b1;
            end
        end
    end

    assign link.eoc_n = eoc_n_reg;
endmodule : converter_end

// >>> pkg/adc_link_pkg.sv
// Behaviour
// - Sample stage holds on conversion-start rising edge.
// - After conversion, track and acquire next input.
// - Normal only with standby pin high, bit clear.
// - Standby pin low or power-down bit enters standby.
// - Host waits wake-up time before converting again.
// - Control word is six bits, MSB first.
// - Host writes one byte under write frame sync.
// - Host reads two bytes under read frame sync.
// - Result is sixteen bits, MSB first.
// - Serial clock idles high, falling edge samples.
// - Writes may be longer; first six bits count.
// - End-of-conversion output falls when result ready.
// - Without end-of-conversion, host waits before reading.
// - Format bit selects straight binary or twos complement.
package adc_link_pkg;
    localparam int CLK_NS = 40;
    localparam int CW_BITS = 6;
    localparam int WR_BITS = 8;
    localparam int RD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int CH_BITS = 3;
    localparam int CW_FORMAT = 5;
    localparam int CW_PWRDN = 4;
    localparam int CW_SWCONV = 3;
    localparam logic [5:0] CW_RESET = 6'h00;
    localparam int ACQ_NS_LONG = 600;
    localparam int ACQ_NS_SHORT = 400;
    localparam int WAKE_INT_NS = 2000000;
    localparam int WAKE_EXT_NS = 5000;
    localparam int READ_WAIT_NS_LONG = 2200;
    localparam int READ_WAIT_NS_SHORT = 2000;
    localparam int START_LOW_CYC = 2;
    localparam int FIFO_DEPTH = 4;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    function automatic int cycles_min(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cycles_min
endpackage : adc_link_pkg

// >>> pkg/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
    logic link_clk;
    logic write_frame_sync_n;
    logic read_frame_sync_n;
    logic data_in;
    logic data_out;
    logic data_out_oe;
    logic conversion_start_n;
    logic standby_n;
    logic eoc_n;

    modport device(
        input link_clk,
        input write_frame_sync_n,
        input read_frame_sync_n,
        input data_in,
        input conversion_start_n,
        input standby_n,
        output data_out,
        output data_out_oe,
        output eoc_n
    );

    modport host(
        output link_clk,
        output write_frame_sync_n,
        output read_frame_sync_n,
        output data_in,
        output conversion_start_n,
        output standby_n,
        input data_out,
        input data_out_oe,
        input eoc_n
    );
endinterface : adc_link_if

// >>> rtl/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW-1:0] wr_next = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    wire [AW-1:0] rd_next = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

    assign in_ready = count != (AW + 1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_next;
            end
            if (pop) begin
                rd_ptr <= rd_next;
            end
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : sample_fifo

// >>> rtl/host_end.sv
`timescale 1ns/1ps
module host_end
    import adc_link_pkg::*;
#(
    parameter int HALF = 2,
    parameter int WAKE_CYC = cycles_min(WAKE_INT_NS)
) (
    input wire logic clk_sys,
    input wire logic rst,
    adc_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [CW_BITS-1:0] cmd_word,
    input wire logic start_req,
    input wire logic standby_req,
    output logic waking,
    output logic res_valid,
    input wire logic res_ready,
    output logic [RD_BITS-1:0] res_data
);
    localparam int WW = $clog2(WAKE_CYC + 1);

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SETUP = 2'b01,
        H_SHIFT = 2'b10,
        H_END = 2'b11
    } host_state_type;

    host_state_type state;
    logic [7:0] div_count;
    logic [4:0] bit_count;
    logic is_read;
    logic sclk;
    logic wfs_n;
    logic rfs_n;
    logic [RD_BITS-1:0] shreg;
    logic [RD_BITS-1:0] rx;
    logic push;
    logic fifo_ready;
    logic [2:0] eoc_sync;
    logic eoc_stable;
    logic eoc_pending;
    logic [WW-1:0] wake_count;
    logic start_low;
    logic [1:0] start_count;
    logic standby_q;
    logic pwrdn_q;

    wire tick = div_count == 8'(HALF - 1);
    wire [4:0] last_bit = is_read ? 5'(RD_BITS - 1) : 5'(WR_BITS - 1);
    wire eoc_next = (eoc_sync[1] & eoc_sync[2])
        | (eoc_stable & (eoc_sync[1] | eoc_sync[2]));
    wire eoc_fall = eoc_stable & ~eoc_next;
    assign cmd_ready = state == H_IDLE;
    wire write_go = cmd_valid && cmd_ready;
    wire read_go = cmd_ready && !cmd_valid && eoc_pending && fifo_ready;
    assign waking = wake_count != '0;
    wire pwrdn_off = write_go && pwrdn_q && !cmd_word[CW_PWRDN];
    wire wake_load = (standby_q && !standby_req) || pwrdn_off;

    assign link.link_clk = sclk;
    assign link.write_frame_sync_n = wfs_n;
    assign link.read_frame_sync_n = rfs_n;
    assign link.data_in = shreg[RD_BITS-1];
    assign link.conversion_start_n = ~start_low;
    assign link.standby_n = ~standby_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= H_IDLE;
            div_count <= '0;
            bit_count <= '0;
            is_read <= 1'b0;
            sclk <= 1'b1;
            wfs_n <= 1'b1;
            rfs_n <= 1'b1;
            shreg <= WORD_ZERO;
            rx <= WORD_ZERO;
            push <= 1'b0;
        end else begin
            push <= 1'b0;
            div_count <= (state == H_IDLE || tick) ? '0 : div_count + 8'h1;
            unique case (state)
                H_IDLE: begin
                    if (write_go) begin
                        shreg <= {cmd_word, {(RD_BITS - CW_BITS){1'b0}}};
                        is_read <= 1'b0;
                        wfs_n <= 1'b0;
                        state <= H_SETUP;
                    end else if (read_go) begin
                        shreg <= WORD_ZERO;
                        is_read <= 1'b1;
                        rfs_n <= 1'b0;
                        state <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    if (tick) begin
                        sclk <= 1'b0;
                        rx <= {rx[RD_BITS-2:0], link.data_out};
                        bit_count <= '0;
                        state <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (tick && !sclk) begin
                        sclk <= 1'b1;
                        shreg <= {shreg[RD_BITS-2:0], 1'b0};
                        bit_count <= bit_count + 5'h1;
                        if (bit_count == last_bit) begin
                            state <= H_END;
                        end
                    end else if (tick) begin
                        sclk <= 1'b0;
                        rx <= {rx[RD_BITS-2:0], link.data_out};
                    end
                end
                H_END: begin
                    if (tick) begin
                        wfs_n <= 1'b1;
                        rfs_n <= 1'b1;
                        push <= is_read;
                        state <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // The end-of-conversion pin comes from the other party's clock.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eoc_sync <= 3'h7;
            eoc_stable <= 1'b1;
            eoc_pending <= 1'b0;
        end else begin
            eoc_sync <= {eoc_sync[1:0], link.eoc_n};
            eoc_stable <= eoc_next;
            eoc_pending <= eoc_fall | (eoc_pending & ~read_go);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            standby_q <= 1'b0;
            pwrdn_q <= 1'b0;
            wake_count <= '0;
            start_low <= 1'b0;
            start_count <= '0;
        end else begin
            standby_q <= standby_req;
            if (write_go) begin
                pwrdn_q <= cmd_word[CW_PWRDN];
            end
            if (wake_load) begin
                wake_count <= WW'(WAKE_CYC);
            end else if (waking) begin
                wake_count <= wake_count - WW'(1);
            end
            if (start_req && !start_low && !waking && !standby_q) begin
                start_low <= 1'b1;
                start_count <= 2'(START_LOW_CYC - 1);
            end else if (start_low && start_count == '0) begin
                start_low <= 1'b0;
            end else if (start_low) begin
                start_count <= start_count - 2'h1;
            end
        end
    end

    sample_fifo #(
        .WIDTH(RD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_results (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(rx),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );
endmodule : host_end

// >>> verif/adc_link_checker.sv
`timescale 1ns/1ps
module adc_link_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic write_frame_sync_n,
    input wire logic read_frame_sync_n,
    input wire logic data_in,
    input wire logic data_out,
    input wire logic data_out_oe,
    input wire logic conversion_start_n,
    input wire logic standby_n,
    input wire logic eoc_n
);
    logic sclk_prev;
    logic [4:0] wr_falls;
    logic [4:0] rd_falls;
    wire logic sclk_fall = sclk_prev & ~link_clk;
    wire logic [4:0] fall_inc = {4'h0, sclk_fall};

    // The host makes the serial clock from clk_sys, so it samples cleanly.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_prev <= 1'b1;
            wr_falls <= 5'h00;
            rd_falls <= 5'h00;
        end else begin
            sclk_prev <= link_clk;
            wr_falls <= write_frame_sync_n ? 5'h00 : wr_falls + fall_inc;
            rd_falls <= read_frame_sync_n ? 5'h00 : rd_falls + fall_inc;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_WR_LEN:
        assert property ($rose(write_frame_sync_n) |-> wr_falls == 5'h08)
        else $error("Write frame clock count wrong.");
    AST_RD_LEN:
        assert property ($rose(read_frame_sync_n) |-> rd_falls == 5'h10)
        else $error("Read frame clock count wrong.");
    AST_SCLK_IDLE:
        assert property (write_frame_sync_n && read_frame_sync_n |-> link_clk)
        else $error("Serial clock not high between frames.");
    AST_ONE_FRAME:
        assert property (!(write_frame_sync_n == 1'b0 &&
                           read_frame_sync_n == 1'b0))
        else $error("Write and read frames overlap.");
    AST_START_PULSE:
        assert property ($fell(conversion_start_n) |=>
                         !conversion_start_n ##1 conversion_start_n)
        else $error("Conversion start pulse width wrong.");
    AST_DIN_STEADY:
        assert property (!write_frame_sync_n && $past(!write_frame_sync_n)
                         && $changed(data_in) |-> $rose(link_clk))
        else $error("Write data moved off the clock rise.");
    AST_EOC_FALL:
        assert property ($fell(eoc_n) |-> read_frame_sync_n)
        else $error("End of conversion fell inside a read.");
    AST_EOC_CLEAR:
        assert property ($fell(read_frame_sync_n) |-> ##[0:6] eoc_n)
        else $error("End of conversion not cleared by read.");
    AST_OE_ON:
        assert property ($fell(read_frame_sync_n) |-> ##[0:5] data_out_oe)
        else $error("Data output not driven in read frame.");

    cover property ($rose(write_frame_sync_n));
    cover property ($rose(read_frame_sync_n));
    cover property ($fell(standby_n));
endmodule : adc_link_checker

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import adc_link_pkg::*;
    logic clk_sys, rst, cmd_valid, start_req, standby_req, res_ready;
    logic cmd_ready, waking, res_valid, conv_done, conv_go, hold, acquiring;
    logic powered_down, twos_format;
    logic [CW_BITS-1:0] cmd_word;
    logic [RD_BITS-1:0] res_data;
    logic [CODE_BITS-1:0] conv_code, core_code;
    logic [CH_BITS-1:0] channel;
    logic [3:0] busy_cnt;
    int miscompares, num_checks;

    adc_link_if link();
    host_end #(.HALF(2), .WAKE_CYC(8)) i_host_end (.clk_sys(clk_sys),
        .rst(rst), .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_word(cmd_word), .start_req(start_req),
        .standby_req(standby_req), .waking(waking), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data));
    converter_end #(.ACQ_NS(ACQ_NS_LONG)) i_converter_end (.clk_sys(clk_sys),
        .rst(rst), .link(link), .conv_done(conv_done),
        .conv_code(conv_code), .conv_go(conv_go), .hold(hold),
        .channel(channel), .acquiring(acquiring),
        .powered_down(powered_down), .twos_format(twos_format));
    adc_link_checker i_adc_link_checker (.clk_sys(clk_sys), .rst(rst),
        .link_clk(link.link_clk), .write_frame_sync_n(link.write_frame_sync_n),
        .read_frame_sync_n(link.read_frame_sync_n), .data_in(link.data_in),
        .data_out(link.data_out), .data_out_oe(link.data_out_oe),
        .conversion_start_n(link.conversion_start_n),
        .standby_n(link.standby_n), .eoc_n(link.eoc_n));

    // Analog core stand-in: the code is only right in the done cycle.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_cnt <= 4'h0;
            conv_done <= 1'b0;
            conv_code <= 12'h000;
        end else begin
            conv_done <= (busy_cnt == 4'h1);
            conv_code <= (busy_cnt == 4'h1) ? core_code : ~core_code;
            if (conv_go) busy_cnt <= 4'hA;
            else if (busy_cnt != 4'h0) busy_cnt <= busy_cnt - 4'h1;
        end
    end

    function automatic logic [15:0] exp_word(input logic [11:0] c,
                                             input logic t);
        return t ? {4'h0, c} - 16'h0800 : {4'h0, c};
    endfunction : exp_word

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // Reading right after the edge gives the value the design sampled.
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (s !== v && n < lim);
    endtask : wait_lvl

    task automatic issue_cmd(input logic [5:0] w);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        wait_lvl(cmd_ready, 1'b1, 300);
        cmd_valid <= 1'b0;
    endtask : issue_cmd

    task automatic finish_cmd;
        repeat (3) @(posedge clk_sys);
        wait_lvl(cmd_ready, 1'b1, 300);
        repeat (8) @(posedge clk_sys);
    endtask : finish_cmd

    task automatic send_cmd(input logic [5:0] w);
        issue_cmd(w);
        finish_cmd();
    endtask : send_cmd

    task automatic do_conv(input logic [11:0] c);
        int n;
        @(posedge clk_sys);
        start_req <= 1'b1;
        core_code <= c;
        @(posedge clk_sys);
        start_req <= 1'b0;
        wait_lvl(hold, 1'b1, 40);
        check(hold, 1'b1);
        wait_lvl(hold, 1'b0, 40);
        n = (acquiring === 1'b1) ? 1 : 0;
        repeat (30) begin
            @(posedge clk_sys);
            if (acquiring === 1'b1) n++;
        end
        check(n, (ACQ_NS_LONG + CLK_NS - 1) / CLK_NS);
        repeat (60) @(posedge clk_sys);
    endtask : do_conv

    task automatic pop(input logic [15:0] exp);
        wait_lvl(res_valid, 1'b1, 300);
        check(res_data, exp);
        res_ready <= 1'b1;
        @(posedge clk_sys);
        res_ready <= 1'b0;
    endtask : pop

    task automatic t_write_cfg;
        issue_cmd(6'h25);
        repeat (10) @(posedge clk_sys);
        check(channel, 3'h0);
        check(twos_format, 1'b0);
        finish_cmd();
        check(channel, 3'h5);
        check(twos_format, 1'b1);
        check(powered_down, 1'b0);
        $display("write config done");
    endtask : t_write_cfg

    task automatic t_codes;
        logic [11:0] codes [4] = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};
        for (int f = 1; f >= 0; f--) begin
            send_cmd({f[0], 5'h02});
            foreach (codes[i]) begin
                do_conv(codes[i]);
                pop(exp_word(codes[i], f[0]));
            end
        end
        $display("coding done");
    endtask : t_codes

    task automatic t_sw_conv;
        core_code <= 12'h5A3;
        issue_cmd(6'h0C);
        wait_lvl(hold, 1'b1, 150);
        check(hold, 1'b1);
        check(channel, 3'h4);
        pop(exp_word(12'h5A3, 1'b0));
        finish_cmd();
        $display("software conversion done");
    endtask : t_sw_conv

    task automatic t_standby;
        int n;
        standby_req <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check(powered_down, 1'b1);
        start_req <= 1'b1;
        @(posedge clk_sys);
        start_req <= 1'b0;
        // The host holds its own starts off, so a software start tests
        // that the device itself refuses to convert in standby.
        issue_cmd(6'h08);
        n = 0;
        repeat (50) begin
            @(posedge clk_sys);
            if (hold === 1'b1) n++;
        end
        check(n, 0);
        finish_cmd();
        standby_req <= 1'b0;
        wait_lvl(waking, 1'b1, 20);
        check(waking, 1'b1);
        wait_lvl(waking, 1'b0, 100);
        repeat (6) @(posedge clk_sys);
        check(powered_down, 1'b0);
        send_cmd(6'h10);
        check(powered_down, 1'b1);
        send_cmd(6'h00);
        check(powered_down, 1'b0);
        $display("standby done");
    endtask : t_standby

    task automatic t_fifo;
        for (int i = 0; i < 5; i++) do_conv(12'h100 + 12'(i));
        check(res_valid, 1'b1);
        for (int i = 0; i < 5; i++) pop({4'h0, 12'h100 + 12'(i)});
        $display("buffer fill done");
    endtask : t_fifo

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Tests take well under 10k cycles; this bound only catches a hang.
    initial begin
        repeat (40000) @(posedge clk_sys);
        miscompares++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_word = 6'h00;
        start_req = 1'b0;
        standby_req = 1'b0;
        res_ready = 1'b0;
        core_code = 12'h000;
        miscompares = 0;
        num_checks = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_write_cfg();
        t_codes();
        t_sw_conv();
        t_standby();
        t_fifo();
        give_verdict();
    end
endmodule : tb_top
